// ---- hw/sbs_pkg.sv ----
// Purpose: Shared constants and types for the burst SRAM cycle logic
// Assumes: One rising-edge clock; all control pins active as named
// Notes: Defaults describe the 36-bit version
package sbs_pkg;
	// Word organisation
	localparam int SBS_LANE_W = 9;
	localparam int SBS_LANES_X36 = 4;
	localparam int SBS_LANES_X18 = 2;
	localparam int SBS_ADDR_W_X36 = 18;
	localparam int SBS_ADDR_W_X18 = 19;
	// Burst counter
	localparam int SBS_CNT_W = 2;
	localparam logic [1:0] SBS_CNT_RST = 2'h0;
	localparam logic [1:0] SBS_CNT_STEP = 2'h1;
	localparam logic [1:0] SBS_LIN_TWO = 2'h2;
	localparam logic [1:0] SBS_FIRST_STEP = 2'h1;
	// Cycle kind of the previous edge
	typedef enum logic [1:0] {
		SBS_IDLE,
		SBS_READ,
		SBS_WRITE
	} sbs_cycle_e;
	// Synchronous control pins sampled each edge
	typedef struct packed {
		logic chip_sel_n;
		logic depth_select_high;
		logic depth_select_low_n;
		logic processor_addr_strobe_n;
		logic controller_addr_strobe_n;
		logic burst_advance_n;
		logic global_write_n;
		logic byte_write_enable_n;
	} sbs_ctrl_s;
endpackage : sbs_pkg

// ---- hw/sbs_cycle_logic.sv ----
// Purpose: Cycle decode, burst addressing and data bus control of a pipelined burst SRAM
// Assumes: Inputs synchronous to i_core_clk; output enable and i_rst are asynchronous
// Notes: Read data appears at the same edge that decodes the cycle
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Burst order pin high: low address bits are start bits XOR a counter 0..3.
// - Burst order pin low: low address bits step linearly, wrapping 11 to 00.
// - Chip select high with controller strobe, or chip select low with depth select off and either strobe: deselect.
// - Selected chip with processor strobe low registers address and starts a read.
// - Controller strobe start registers address, writes if write condition low, else reads.
// - Both strobes high, advance low: step burst address, read or write.
// - Both strobes high, advance high: keep address, read or write by the write condition.
// - Reads drive bus only while output enable low; writes keep bus input.
// - 36-bit write condition: global write low, or byte enable and any lane low.
// - 18-bit write condition has the same form: global write low, or byte enable and either of two lanes low.
// - Each lane enable writes only its own byte lane.
// - Global write high with byte enable high or all lanes high is a read.
// - All inputs but output enable and i_rst sampled at rising edge; output enable and i_rst asynchronous.
// - Data outputs stay high impedance during power up.
module sbs_cycle_logic import sbs_pkg::*; #(
	parameter int LANES = SBS_LANES_X36,
	parameter int ADDR_W = SBS_ADDR_W_X36
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire sbs_ctrl_s i_ctrl,
	input wire logic [LANES-1:0] i_lane_write_n,
	input wire logic i_burst_order,
	input wire logic i_out_enable_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [LANES*SBS_LANE_W-1:0] i_data,
	output logic [LANES*SBS_LANE_W-1:0] o_data,
	output logic o_data_oe,
	output logic o_powered_down
);
	localparam int DATA_W = LANES * SBS_LANE_W;
	localparam int UP_W = ADDR_W - SBS_CNT_W;

	// Burst low bits from start bits and counter
	function automatic logic [1:0] burst_low(input logic [1:0] base, input logic [1:0] cnt,
		input logic interleave);
		burst_low = interleave ? (base ^ cnt) : 2'(base + cnt);
	endfunction : burst_low

	sbs_cycle_e state_q, state_d;
	logic [UP_W-1:0] upper_q;
	logic [1:0] base_q, cnt_q;
	logic [DATA_W-1:0] o_data_q;
	logic down_q;
	wire logic [DATA_W-1:0] rd_word;

	// Chip and strobe decode
	wire logic sel_ok = i_ctrl.depth_select_high & ~i_ctrl.depth_select_low_n;
	wire logic p_low = ~i_ctrl.processor_addr_strobe_n;
	wire logic c_low = ~i_ctrl.controller_addr_strobe_n;
	wire logic cs = ~i_ctrl.chip_sel_n;
	wire logic desel = (~cs & c_low) | (cs & ~sel_ok & (p_low | c_low));
	wire logic start_p = cs & sel_ok & p_low;
	wire logic start_c = cs & sel_ok & ~p_low & c_low;
	wire logic start = start_p | start_c;
	wire logic cont = ~c_low & (~p_low | ~cs);
	wire logic active = state_q != SBS_IDLE;
	wire logic advance = active & cont & ~i_ctrl.burst_advance_n;
	wire logic hold = active & cont & i_ctrl.burst_advance_n;
	wire logic do_cycle = start | advance | hold;

	// Write qualification, one enable per lane
	// A processor start reads even with write pins low; a write waits a cycle
	wire logic write_n = i_ctrl.global_write_n &
		(i_ctrl.byte_write_enable_n | (&i_lane_write_n));
	wire logic write_cyc = do_cycle & ~write_n & ~start_p;
	wire logic [LANES-1:0] lane_we = {LANES{~i_ctrl.global_write_n}} |
		({LANES{~i_ctrl.byte_write_enable_n}} & ~i_lane_write_n);

	// Burst address of this edge
	// Only the low bits move; the upper bits stay as loaded
	wire logic [1:0] cur_low = burst_low(base_q, cnt_q, i_burst_order);
	wire logic [1:0] nxt_low = burst_low(base_q, 2'(cnt_q + SBS_CNT_STEP), i_burst_order);
	wire logic [1:0] addr_low = i_addr[SBS_CNT_W-1:0];
	wire logic [ADDR_W-1:0] eff_addr = start ? i_addr :
		advance ? {upper_q, nxt_low} : {upper_q, cur_low};

	// Cycle kind decided at this edge
	// Deselect wins over a start, and a start over a continue
	assign state_d = desel ? SBS_IDLE :
		!do_cycle ? state_q :
		write_cyc ? SBS_WRITE : SBS_READ;

	// Cycle state and burst counter
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= SBS_IDLE;
			upper_q <= '0;
			base_q <= SBS_CNT_RST;
			cnt_q <= SBS_CNT_RST;
			down_q <= 1'b1;
		end else begin
			state_q <= state_d;
			down_q <= desel | (~active & ~start);
			if (start) begin
				upper_q <= i_addr[ADDR_W-1:SBS_CNT_W];
				base_q <= addr_low;
				cnt_q <= SBS_CNT_RST;
			end else if (advance) begin
				cnt_q <= 2'(cnt_q + SBS_CNT_STEP);
			end
		end
	end

	// One array per byte lane
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			logic [SBS_LANE_W-1:0] mem [0:(2**ADDR_W)-1];
			// Lane write, only its own enable
			always_ff @(posedge i_core_clk) begin
				if (write_cyc && lane_we[g]) begin
					mem[eff_addr] <= i_data[g*SBS_LANE_W +: SBS_LANE_W];
				end
			end
			assign rd_word[g*SBS_LANE_W +: SBS_LANE_W] = mem[eff_addr];
			// A lane takes data only with its own enable or global write
			lane_own_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
				lane_we[g] |-> !i_ctrl.global_write_n ||
				(!i_ctrl.byte_write_enable_n && !i_lane_write_n[g]))
				else $error("lane written without its enable");
		end
	endgenerate

	// Pipelined read data register
	// A read of the address written the cycle before returns the new word
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_data_q <= '0;
		end else if (do_cycle && !write_cyc && !desel) begin
			o_data_q <= rd_word;
		end
	end

	// Output enable acts without the clock, so the drive enable is the one
	// output that is not taken from a register
	assign o_data = o_data_q;
	assign o_data_oe = (state_q == SBS_READ) & ~i_out_enable_n;
	assign o_powered_down = down_q;

	// Checks sleep while reset is held
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	// Deselect floats the bus
	deselect_floats_a: assert property (desel |=> !o_data_oe && state_q == SBS_IDLE)
		else $error("bus driven after deselect");
	// Processor strobe start is always a read at the given address
	pstart_read_a: assert property (start_p |=> state_q == SBS_READ &&
		{upper_q, base_q} == $past(i_addr) && cnt_q == SBS_CNT_RST)
		else $error("processor start not a read");
	// Controller strobe start follows the write condition
	cstart_kind_a: assert property (start_c |=>
		(state_q == SBS_WRITE) == !$past(write_n))
		else $error("controller start kind wrong");
	// Interleaved second address
	interleave_step_a: assert property ((start && i_burst_order) ##1
		(advance && i_burst_order) |=> cur_low == ($past(addr_low, 2) ^ SBS_FIRST_STEP))
		else $error("interleaved step wrong");
	// Linear third address wraps
	linear_step_a: assert property ((start && !i_burst_order) ##1
		(advance && !i_burst_order) [*2] |=> cur_low == 2'($past(addr_low, 3) + SBS_LIN_TWO))
		else $error("linear step wrong");
	// Suspend keeps the address
	suspend_hold_a: assert property (hold && !start |=>
		cnt_q == $past(cnt_q) && base_q == $past(base_q))
		else $error("address moved during wait");
	// Upper bits fixed within a burst
	upper_fixed_a: assert property (!start |=> upper_q == $past(upper_q))
		else $error("upper address changed in burst");
	// Bus direction by cycle kind
	bus_direction_a: assert property (state_q != SBS_READ |-> !o_data_oe)
		else $error("bus driven outside read");
	// Global write writes all lanes
	global_write_a: assert property (!i_ctrl.global_write_n |-> !write_n && &lane_we)
		else $error("global write missed lanes");
	// Read when no lane requested
	byte_read_a: assert property (i_ctrl.global_write_n && (i_ctrl.byte_write_enable_n ||
		&i_lane_write_n) |-> write_n && !write_cyc)
		else $error("write without lane enable");
	// Deselect also powers the array down
	desel_power_a: assert property (desel |=> o_powered_down)
		else $error("no power down after deselect");
	// Any start wakes the array
	start_wake_a: assert property (start |=> !o_powered_down)
		else $error("still powered down after start");
	// Controller start loads the whole address
	cstart_addr_a: assert property (start_c |=> cnt_q == SBS_CNT_RST &&
		{upper_q, base_q} == $past(i_addr))
		else $error("controller start address wrong");
	// Advance moves the counter by one, wrapping
	advance_count_a: assert property (advance |=>
		cnt_q == 2'($past(cnt_q) + SBS_CNT_STEP))
		else $error("burst counter did not advance");
	// Continue with no open burst starts nothing
	idle_continue_a: assert property (!active && cont |=> state_q == SBS_IDLE)
		else $error("continue started a cycle");
	// Wait cycles repeat the access kind of their write condition
	hold_write_a: assert property (hold && !write_n |=> state_q == SBS_WRITE)
		else $error("wait cycle did not write");
	hold_read_a: assert property (hold && write_n |=> state_q == SBS_READ)
		else $error("wait cycle did not read");
	// Read cycles load the addressed word
	read_load_a: assert property (do_cycle && !write_cyc |=>
		o_data == $past(rd_word))
		else $error("read data not loaded");
	// Output enable high floats the bus without waiting for the clock
	oe_float_a: assert property (i_out_enable_n |-> !o_data_oe)
		else $error("bus driven with output enable high");
	// Any requested lane makes a write
	write_cond_a: assert property (!i_ctrl.global_write_n ||
		(!i_ctrl.byte_write_enable_n && !(&i_lane_write_n)) |-> !write_n)
		else $error("write condition missed");
endmodule : sbs_cycle_logic

`default_nettype wire

// ---- testbench/sbs_ctl_model.sv ----
// Purpose: Memory controller model driving the burst SRAM pins
// Assumes: Pins change just after the rising edge and stay a full cycle
// Notes: Idle pins keep the chip selected with no strobe and no write
`timescale 1ns/10ps
`default_nettype none
module sbs_ctl_model import sbs_pkg::*; (
	input wire logic i_core_clk,
	output var sbs_ctrl_s o_ctrl,
	output logic [3:0] o_lane_write_n,
	output logic [3:0] o_addr,
	output logic [35:0] o_data,
	output logic o_out_enable_n
);
	// Idle levels from time zero
	initial begin
		o_ctrl = sbs_ctrl_s'(8'h5f);
		o_lane_write_n = 4'hf;
		o_addr = 4'h0;
		o_data = 36'h0_0000_0000;
		o_out_enable_n = 1'b1;
	end
	// One beat: launch after the edge, return once settled
	task automatic beat(input logic [7:0] c, input logic [3:0] a, input logic [35:0] d,
		input logic [3:0] l, input logic oe_n);
		@(posedge i_core_clk);
		o_ctrl <= sbs_ctrl_s'(c);
		o_addr <= a;
		o_data <= d;
		o_lane_write_n <= l;
		o_out_enable_n <= oe_n;
		#1;
	endtask : beat
endmodule : sbs_ctl_model
`default_nettype wire

// ---- testbench/sbs_cycle_logic_tb.sv ----
// Purpose: Self-checking bench for the burst SRAM cycle logic
// Assumes: Four-bit address for a short memory
// Notes: Each check judges the edge of the previous beat
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module sbs_cycle_logic_tb;
	import sbs_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	logic order = 1'b0;
	sbs_ctrl_s ctrl;
	logic [3:0] lanes, addr;
	logic [35:0] wd, rd;
	logic oe_n, oe, pd;
	int n_errors = 0;
	int samples_checked = 0;
	sbs_ctl_model sbs_ctl_model_inst (.i_core_clk(i_core_clk), .o_ctrl(ctrl),
		.o_lane_write_n(lanes), .o_addr(addr), .o_data(wd), .o_out_enable_n(oe_n));
	sbs_cycle_logic #(.ADDR_W(4)) sbs_cycle_logic_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_ctrl(ctrl), .i_lane_write_n(lanes), .i_burst_order(order), .i_out_enable_n(oe_n),
		.i_addr(addr), .i_data(wd), .o_data(rd), .o_data_oe(oe), .o_powered_down(pd));
	// Clock at 100 MHz
	initial begin
		forever #5 i_core_clk = ~i_core_clk;
	end
	// Word stored at each address
	function automatic logic [35:0] f(input logic [3:0] a);
		return 36'h0_a5a5_0000 | 36'(a);
	endfunction : f
	task automatic bt(input logic [7:0] c, input logic [3:0] a, input logic [35:0] d,
		input logic [3:0] l, input logic o);
		sbs_ctl_model_inst.beat(c, a, d, l, o);
	endtask : bt
	// Full-word write burst from address 5, linear order
	task automatic t_write;
		bt(8'h55, 4'h5, f(5), 4'hf, 1'b0);
		bt(8'h59, 4'h0, f(6), 4'hf, 1'b0);
		`CHK(oe, 1'b0)
		bt(8'h59, 4'h0, f(7), 4'hf, 1'b0);
		bt(8'h59, 4'h0, f(4), 4'hf, 1'b0);
	endtask : t_write
	// Read burst of four plus a suspend beat
	task automatic t_read(input logic [3:0] a, input logic [15:0] seq);
		bt(8'h4f, a, 36'h0_0000_0000, 4'hf, 1'b0);
		for (int k = 0; k < 4; k++) begin
			bt(k < 3 ? 8'h5b : 8'h5f, 4'h0, 36'h0_0000_0000, 4'hf, 1'b0);
			`CHK(rd, f(seq[15-4*k -: 4]))
		end
		`CHK(oe, 1'b1)
		bt(8'h5b, 4'h0, 36'h0_0000_0000, 4'hf, 1'b0);
		`CHK(rd, f(seq[3:0]))
		bt(8'h5f, 4'h0, 36'h0_0000_0000, 4'hf, 1'b0);
		`CHK(rd, f(seq[15:12]))
	endtask : t_read
	// Lane write, void byte write, processor start with write pins low
	task automatic t_lanes;
		bt(8'h56, 4'h4, 36'h0_0000_01ff, 4'he, 1'b1);
		bt(8'h56, 4'h6, 36'h0_0000_0000, 4'hf, 1'b0);
		bt(8'h4d, 4'h4, 36'h0_0000_0000, 4'hf, 1'b0);
		`CHK(rd, f(6))
		`CHK(oe, 1'b1)
		bt(8'h5b, 4'h0, 36'h0_0000_0000, 4'hf, 1'b0);
		`CHK(rd, f(4) | 36'h0_0000_01ff)
		bt(8'h5f, 4'h0, 36'h0_0000_0000, 4'hf, 1'b1);
		`CHK(rd, f(5))
		`CHK(oe, 1'b0)
	endtask : t_lanes
	// Processor start, then a write in the wait cycle after it
	task automatic t_pwrite;
		bt(8'h4f, 4'h6, 36'h0_0000_0000, 4'hf, 1'b1);
		bt(8'h5d, 4'h0, 36'h0_1234_5678, 4'hf, 1'b1);
		bt(8'h4f, 4'h6, 36'h0_0000_0000, 4'hf, 1'b0);
		`CHK(oe, 1'b0)
		bt(8'h5f, 4'h0, 36'h0_0000_0000, 4'hf, 1'b0);
		`CHK(rd, 36'h0_1234_5678)
	endtask : t_pwrite
	// Each deselect form ends an open read burst and floats the bus
	task automatic t_desel(input logic [7:0] c);
		bt(8'h4f, 4'h6, 36'h0_0000_0000, 4'hf, 1'b0);
		bt(c, 4'h0, 36'h0_0000_0000, 4'hf, 1'b0);
		`CHK({pd, oe}, 2'b01)
		bt(8'h5f, 4'h0, 36'h0_0000_0000, 4'hf, 1'b0);
		`CHK({pd, oe}, 2'b10)
	endtask : t_desel
	task automatic give_verdict;
		$display("errors=%0d checks=%0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict
	// Main sequence
	initial begin
		repeat (16) @(posedge i_core_clk);
		i_rst <= 1'b0;
		#1;
		`CHK({pd, oe}, 2'b10)
		t_write();
		t_read(4'h7, 16'h7456);
		@(posedge i_core_clk);
		order <= 1'b1;
		t_read(4'h5, 16'h5476);
		t_lanes();
		t_pwrite();
		t_desel(8'hd7);
		t_desel(8'h0f);
		t_desel(8'h77);
		give_verdict();
	end
endmodule : sbs_cycle_logic_tb
`default_nettype wire
